// ### arc_regs.sv
// Auxiliary output, reference trim and calibration control registers with the self-calibration sequencer.
// Assumes a host serial controller on ref_clk presenting one-cycle read and write strobes.
`timescale 1ns/1ps
module arc_regs #(
   parameter int unsigned CAL_TICKS = 64 // Calibration clock ticks per self-calibration
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [5:0] user_cal_ref,
   output arc_pkg::arc_aux_s aux_i_cfg,
   output arc_pkg::arc_aux_s aux_q_cfg,
   output logic [11:0] aux_i_span_mv,
   output logic [11:0] aux_i_top_mv,
   output logic [11:0] aux_q_span_mv,
   output logic [11:0] aux_q_top_mv,
   output logic signed [5:0] reference_trim_code,
   output logic [5:0] q_cal_ref_preload,
   output logic [5:0] i_cal_ref_preload,
   output logic cal_tick,
   output logic cal_busy,
   output logic q_cal_done,
   output logic i_cal_done
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers shared by both channels
   // Span code to millivolts
   function automatic logic [11:0] span_mv(input logic [1:0] code);
      case (code)
         2'h0: span_mv = 12'h7D0;   // 2.0 V
         2'h1: span_mv = 12'h5DC;   // 1.5 V
         2'h2: span_mv = 12'h3E8;   // 1.0 V
         default: span_mv = 12'h1F4; // 0.5 V
      endcase
   endfunction

   // Top-of-range code to millivolts; unlisted codes hold the highest setting
   function automatic logic [11:0] top_mv(input logic [2:0] code);
      case (code)
         3'h0: top_mv = 12'h3E8;    // 1.0 V
         3'h1: top_mv = 12'h5DC;    // 1.5 V
         3'h2: top_mv = 12'h7D0;    // 2.0 V
         3'h3: top_mv = 12'h9C4;    // 2.5 V
         default: top_mv = 12'hB54; // 2.9 V
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Reset synchroniser: assert at once, release after two edges
   logic [1:0] rst_sync_r;
   logic rst_n_int;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync_r[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [7:0] i_low_r;    // aux_i_level_low
   logic [7:0] i_ctl_r;    // aux_i_control
   logic [7:0] q_low_r;    // aux_q_level_low
   logic [7:0] q_ctl_r;    // aux_q_control
   logic [5:0] trim_r;     // reference_trim_code
   logic [7:0] cal_ctl_r;  // calibration_control
   logic wr_hit_mem;       // Write to memory control register

   // Host writes; the status offset is read-only and unmapped offsets are ignored
   always_ff @(posedge ref_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         i_low_r <= arc_pkg::ARC_RST_REG;
         i_ctl_r <= arc_pkg::ARC_RST_REG;
         q_low_r <= arc_pkg::ARC_RST_REG;
         q_ctl_r <= arc_pkg::ARC_RST_REG;
         trim_r <= 6'h00;
         cal_ctl_r <= arc_pkg::ARC_RST_REG;
      end else if (reg_wr_en) begin
         case (reg_addr)
            arc_pkg::ARC_OFS_AUX_I_LOW: i_low_r <= reg_wdata;
            arc_pkg::ARC_OFS_AUX_I_CTL: i_ctl_r <= reg_wdata;
            arc_pkg::ARC_OFS_AUX_Q_LOW: q_low_r <= reg_wdata;
            arc_pkg::ARC_OFS_AUX_Q_CTL: q_ctl_r <= reg_wdata;
            arc_pkg::ARC_OFS_REF_TRIM: trim_r <= reg_wdata[5:0];
            arc_pkg::ARC_OFS_CAL_CTL: cal_ctl_r <= reg_wdata;
            default: begin end // Status, memory control and unmapped offsets store nothing here
         endcase
      end
   end

   assign wr_hit_mem = reg_wr_en && (reg_addr == arc_pkg::ARC_OFS_MEM_CTL);

   ////////////////////////////////////////////////////////////////////////////////
   // Field views of the stored registers
   logic q_preload_source;
   logic i_preload_source;
   logic q_selfcal_select;
   logic i_selfcal_select;
   logic cal_clock_enable;
   logic [2:0] cal_clock_divide;
   assign q_preload_source = cal_ctl_r[arc_pkg::ARC_CAL_PRELD_Q_BIT];
   assign i_preload_source = cal_ctl_r[arc_pkg::ARC_CAL_PRELD_I_BIT];
   assign q_selfcal_select = cal_ctl_r[arc_pkg::ARC_CAL_SEL_Q_BIT];
   assign i_selfcal_select = cal_ctl_r[arc_pkg::ARC_CAL_SEL_I_BIT];
   assign cal_clock_enable = cal_ctl_r[arc_pkg::ARC_CAL_CLK_EN_BIT];
   assign cal_clock_divide = cal_ctl_r[2:0];

   // Level words join the low byte with the two bottom bits of the control register
   assign aux_q_cfg.enable = q_ctl_r[arc_pkg::ARC_AUX_EN_BIT];
   assign aux_q_cfg.span = q_ctl_r[arc_pkg::ARC_AUX_SPAN_LSB +: 2];
   assign aux_q_cfg.top = q_ctl_r[arc_pkg::ARC_AUX_TOP_LSB +: 3];
   assign aux_q_cfg.level = {q_ctl_r[1:0], q_low_r};
   assign aux_i_cfg.enable = i_ctl_r[arc_pkg::ARC_AUX_EN_BIT];
   assign aux_i_cfg.span = i_ctl_r[arc_pkg::ARC_AUX_SPAN_LSB +: 2];
   assign aux_i_cfg.top = i_ctl_r[arc_pkg::ARC_AUX_TOP_LSB +: 3];
   assign aux_i_cfg.level = {i_ctl_r[1:0], i_low_r};
   assign reference_trim_code = trim_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Registered analog settings in millivolts and preload references
   always_ff @(posedge ref_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         aux_q_span_mv <= 12'h7D0;
         aux_q_top_mv <= 12'h3E8;
         aux_i_span_mv <= 12'h7D0;
         aux_i_top_mv <= 12'h3E8;
      end else begin
         aux_q_span_mv <= span_mv(aux_q_cfg.span);
         aux_q_top_mv <= top_mv(aux_q_cfg.top);
         aux_i_span_mv <= span_mv(aux_i_cfg.span);
         aux_i_top_mv <= top_mv(aux_i_cfg.top);
      end
   end

   // Preload chooses the fixed reference unless software asks for its own value
   always_ff @(posedge ref_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         q_cal_ref_preload <= arc_pkg::ARC_CAL_FIXED_REF;
         i_cal_ref_preload <= arc_pkg::ARC_CAL_FIXED_REF;
      end else begin
         q_cal_ref_preload <= q_preload_source ? user_cal_ref : arc_pkg::ARC_CAL_FIXED_REF;
         i_cal_ref_preload <= i_preload_source ? user_cal_ref : arc_pkg::ARC_CAL_FIXED_REF;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Calibration clock: a tick stream gated by the enable bit
   arc_cal_div u_cal_div (
      .clk(ref_clk),
      .rst_n(rst_n_int),
      .enable(cal_clock_enable),
      .div_code(cal_clock_divide),
      .tick(cal_tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Self-calibration sequencer
   arc_pkg::arc_cal_state_e state_r;
   logic [15:0] tick_cnt_r;   // Ticks spent in the run state
   logic sel_q_r;             // Q channel in the running calibration
   logic sel_i_r;             // I channel in the running calibration
   logic start;               // Accepted start request
   logic run_end;             // Last tick of the run
   logic [1:0] q_mem_r;       // Q calibration memory status
   logic [1:0] i_mem_r;       // I calibration memory status

   // A start while busy is dropped; a zero in the start bit does nothing
   assign start = wr_hit_mem && reg_wdata[arc_pkg::ARC_MEM_START_BIT] &&
                  (state_r == arc_pkg::ARC_CAL_IDLE) && (q_selfcal_select || i_selfcal_select);
   assign run_end = cal_tick && (tick_cnt_r == 16'(CAL_TICKS - 1));
   assign cal_busy = (state_r != arc_pkg::ARC_CAL_IDLE);

   // The run state is left only on a calibration tick, so a stopped clock freezes the run
   always_ff @(posedge ref_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         state_r <= arc_pkg::ARC_CAL_IDLE;
      end else begin
         case (state_r)
            arc_pkg::ARC_CAL_IDLE: if (start) begin
               state_r <= arc_pkg::ARC_CAL_RUN;
            end
            arc_pkg::ARC_CAL_RUN: if (run_end) begin
               state_r <= arc_pkg::ARC_CAL_FINISH;
            end
            arc_pkg::ARC_CAL_FINISH: state_r <= arc_pkg::ARC_CAL_IDLE;
            default: state_r <= arc_pkg::ARC_CAL_IDLE;
         endcase
      end
   end

   // Tick counter, cleared by each accepted start
   always_ff @(posedge ref_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         tick_cnt_r <= 16'h0000;
      end else if (start) begin
         tick_cnt_r <= 16'h0000;
      end else if (state_r == arc_pkg::ARC_CAL_RUN && cal_tick) begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
   end

   // Channel selection is frozen at the start so mid-run writes cannot tear it
   always_ff @(posedge ref_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         sel_q_r <= 1'b0;
         sel_i_r <= 1'b0;
      end else if (start) begin
         sel_q_r <= q_selfcal_select;
         sel_i_r <= i_selfcal_select;
      end
   end

   // Done flags drop at start and rise at finish; the two never coincide
   always_ff @(posedge ref_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         q_cal_done <= 1'b0;
         i_cal_done <= 1'b0;
         q_mem_r <= arc_pkg::ARC_MEM_UNCAL;
         i_mem_r <= arc_pkg::ARC_MEM_UNCAL;
      end else if (start) begin
         if (q_selfcal_select) begin
            q_cal_done <= 1'b0;
         end
         if (i_selfcal_select) begin
            i_cal_done <= 1'b0;
         end
      end else if (state_r == arc_pkg::ARC_CAL_FINISH) begin
         if (sel_q_r) begin
            q_cal_done <= 1'b1;
            q_mem_r <= arc_pkg::ARC_MEM_SELF;
         end
         if (sel_i_r) begin
            i_cal_done <= 1'b1;
            i_mem_r <= arc_pkg::ARC_MEM_SELF;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path: data one cycle after the read strobe, unmapped offsets read zero
   always_ff @(posedge ref_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd_en) begin
         case (reg_addr)
            arc_pkg::ARC_OFS_AUX_I_LOW: reg_rdata <= i_low_r;
            arc_pkg::ARC_OFS_AUX_I_CTL: reg_rdata <= i_ctl_r;
            arc_pkg::ARC_OFS_AUX_Q_LOW: reg_rdata <= q_low_r;
            arc_pkg::ARC_OFS_AUX_Q_CTL: reg_rdata <= q_ctl_r;
            arc_pkg::ARC_OFS_REF_TRIM: reg_rdata <= {2'h0, trim_r};
            arc_pkg::ARC_OFS_CAL_CTL: reg_rdata <= cal_ctl_r;
            arc_pkg::ARC_OFS_CAL_STAT: reg_rdata <= {q_cal_done, i_cal_done, 2'h0, q_mem_r, i_mem_r};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_q_level_low;
      @(posedge ref_clk) disable iff (!rst_n_int)
      reg_wr_en && reg_addr == 8'h0B |=> aux_q_cfg.level[7:0] == $past(reg_wdata);
   endproperty
   a_q_level_low: assert property (p_q_level_low) else $error("Q level low byte not taken");
   property p_i_level_top;
      @(posedge ref_clk) disable iff (!rst_n_int)
      reg_wr_en && reg_addr == 8'h0A |=> aux_i_cfg.level[9:8] == $past(reg_wdata[1:0]);
   endproperty
   a_i_level_top: assert property (p_i_level_top) else $error("I level top bits not taken");
   property p_q_ctl_fields;
      @(posedge ref_clk) disable iff (!rst_n_int)
      reg_wr_en && reg_addr == 8'h0C |=> aux_q_cfg.enable == $past(reg_wdata[7]) &&
         aux_q_cfg.span == $past(reg_wdata[6:5]) ##1 aux_q_top_mv == top_mv($past(reg_wdata[4:2], 2));
   endproperty
   a_q_ctl_fields: assert property (p_q_ctl_fields) else $error("Q control fields wrong");
   property p_q_span_mv;
      @(posedge ref_clk) disable iff (!rst_n_int)
      $stable(aux_q_cfg.span) && aux_q_cfg.span == 2'h3 |=> aux_q_span_mv == 12'h1F4;
   endproperty
   a_q_span_mv: assert property (p_q_span_mv) else $error("Q span decode wrong");
   property p_trim_read;
      @(posedge ref_clk) disable iff (!rst_n_int)
      reg_rd_en && reg_addr == 8'h0D |=> reg_rdata == {2'h0, $past(trim_r)};
   endproperty
   a_trim_read: assert property (p_trim_read) else $error("Trim readback wrong");
   property p_q_preload;
      @(posedge ref_clk) disable iff (!rst_n_int)
      !q_preload_source ##1 1'b1 |-> q_cal_ref_preload == 6'h20;
   endproperty
   a_q_preload: assert property (p_q_preload) else $error("Q preload not fixed 32");
   property p_cal_clock_gate;
      @(posedge ref_clk) disable iff (!rst_n_int)
      !cal_clock_enable |-> !cal_tick;
   endproperty
   a_cal_clock_gate: assert property (p_cal_clock_gate) else $error("Tick while clock disabled");
   property p_div_two;
      @(posedge ref_clk) disable iff (!rst_n_int)
      cal_tick && cal_clock_divide == 3'h7 ##1 cal_clock_enable ##1 cal_clock_enable |-> cal_tick && !$past(cal_tick);
   endproperty
   a_div_two: assert property (p_div_two) else $error("Divide by two wrong");
   property p_q_done_clear;
      @(posedge ref_clk) disable iff (!rst_n_int)
      start && q_selfcal_select |=> !q_cal_done && cal_busy;
   endproperty
   a_q_done_clear: assert property (p_q_done_clear) else $error("Q done not cleared at start");
   property p_start_zero;
      @(posedge ref_clk) disable iff (!rst_n_int)
      wr_hit_mem && !reg_wdata[4] && !cal_busy |=> !cal_busy;
   endproperty
   a_start_zero: assert property (p_start_zero) else $error("Zero start bit began calibration");

endmodule

// ### arc_pkg.sv
// Constants and types for the auxiliary output, reference trim and calibration register slice.
// Assumes a single converter clock domain; used by arc_regs and arc_cal_div.
package arc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets on the serial register port
   localparam logic [7:0] ARC_OFS_AUX_I_LOW = 8'h09;   // aux_i_level_low
   localparam logic [7:0] ARC_OFS_AUX_I_CTL = 8'h0A;   // aux_i_control
   localparam logic [7:0] ARC_OFS_AUX_Q_LOW = 8'h0B;   // aux_q_level_low
   localparam logic [7:0] ARC_OFS_AUX_Q_CTL = 8'h0C;   // aux_q_control
   localparam logic [7:0] ARC_OFS_REF_TRIM = 8'h0D;    // reference_trim
   localparam logic [7:0] ARC_OFS_CAL_CTL = 8'h0E;     // calibration_control
   localparam logic [7:0] ARC_OFS_CAL_STAT = 8'h0F;    // calibration_status
   localparam logic [7:0] ARC_OFS_MEM_CTL = 8'h12;     // Memory read/write control, strobe bits only

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int ARC_AUX_EN_BIT = 7;          // Auxiliary output enable
   localparam int ARC_AUX_SPAN_LSB = 5;        // Span field 6:5
   localparam int ARC_AUX_TOP_LSB = 2;         // Top-of-range field 4:2
   localparam int ARC_CAL_PRELD_Q_BIT = 7;     // Q preload source
   localparam int ARC_CAL_PRELD_I_BIT = 6;     // I preload source
   localparam int ARC_CAL_SEL_Q_BIT = 5;       // Q self-calibration select
   localparam int ARC_CAL_SEL_I_BIT = 4;       // I self-calibration select
   localparam int ARC_CAL_CLK_EN_BIT = 3;      // Calibration clock enable
   localparam int ARC_STAT_Q_DONE_BIT = 7;     // Q calibration complete
   localparam int ARC_STAT_I_DONE_BIT = 6;     // I calibration complete
   localparam int ARC_MEM_START_BIT = 4;       // Self-calibration start strobe

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and fixed codes
   localparam logic [7:0] ARC_RST_REG = 8'h00;       // All writable registers reset to zero
   localparam logic [5:0] ARC_CAL_FIXED_REF = 6'h20; // Fixed preload reference of 32
   localparam logic [1:0] ARC_MEM_UNCAL = 2'h0;      // Calibration memory status: uncalibrated
   localparam logic [1:0] ARC_MEM_SELF = 2'h1;       // Calibration memory status: self-calibrated
   localparam logic [7:0] ARC_DIV_MAX_TERM = 8'hFF;  // Terminal count for divide by 256
   localparam int ARC_AUX_LEVEL_W = 10;              // Auxiliary level word width

   ////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic enable;                          // Output enabled
      logic [1:0] span;                      // Span select code
      logic [2:0] top;                       // Top-of-range select code
      logic [ARC_AUX_LEVEL_W-1:0] level;     // Output level word
   } arc_aux_s;

   typedef enum logic [1:0] {
      ARC_CAL_IDLE = 2'h0,
      ARC_CAL_RUN = 2'h1,
      ARC_CAL_FINISH = 2'h3
   } arc_cal_state_e;

endpackage

// ### arc_cal_div.sv
// Calibration clock divider: a one-cycle tick every 256 >> code converter clocks.
// Assumes enable and code come from registers on the same clock; reset is already synchronised.
`timescale 1ns/1ps
module arc_cal_div (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic [2:0] div_code,
   output logic tick
);

   logic [7:0] cnt_r;   // Converter clocks since last tick
   logic [7:0] term_r;  // Terminal count now in force

   ////////////////////////////////////////////////////////////////////////////////
   // Tick when the count reaches the terminal value
   assign tick = enable && (cnt_r == term_r);

   // Count runs only while enabled; a stopped clock restarts from zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
      end else if (!enable || tick) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   // New ratio taken only while stopped or at a tick, so no period is ever cut short
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         term_r <= arc_pkg::ARC_DIV_MAX_TERM;
      end else if (!enable || tick) begin
         term_r <= arc_pkg::ARC_DIV_MAX_TERM >> div_code;
      end
   end

endmodule

// ### arc_host_model.sv
// Host serial controller model driving the register port strobes.
// Assumes one bench process calls xfer at a time, on ref_clk.
`timescale 1ns/1ps
module arc_host_model (
   input wire logic ref_clk,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   // Idle bus at time zero
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   ////////////////////////////////////////
   // One-cycle strobe; address and data are inverted once idle
   // so the design cannot lean on stale values
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr_en <= wr;
      reg_rd_en <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule

// ### aux_ref_cal_register_bank_bench.sv
// Self-checking bench for the auxiliary, trim and calibration registers.
// Assumes arc_regs is the top and the host model issues all accesses.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
module aux_ref_cal_register_bank_bench;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_wr_en, reg_rd_en;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, e_v;
   logic [5:0] user_cal_ref = 6'h00;
   arc_pkg::arc_aux_s aux_i_cfg, aux_q_cfg;
   logic [11:0] is_mv, it_mv, qs_mv, qt_mv;
   logic signed [5:0] trim;
   logic [5:0] qpre, ipre;
   logic cal_tick, cal_busy, q_done, i_done;
   logic rd_d = 1'b0;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   logic [31:0] seed = 32'h220233DE; // Fixed seed for repeatable runs
   logic [7:0] exp_q[$]; // Expected read data, oldest first
   logic [7:0] addrs [9] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h12, 8'h3C};
   logic [11:0] span_t [4] = '{12'h7D0, 12'h5DC, 12'h3E8, 12'h1F4}; // mV per span code
   logic [11:0] top_t [5] = '{12'h3E8, 12'h5DC, 12'h7D0, 12'h9C4, 12'hB54}; // mV per top code

   // Converter clock, 10 ns period
   initial forever #5 ref_clk = ~ref_clk;

   arc_host_model host (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   // Short calibration run keeps the simulation brief
   arc_regs #(.CAL_TICKS(2)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .user_cal_ref(user_cal_ref), .aux_i_cfg(aux_i_cfg), .aux_q_cfg(aux_q_cfg),
      .aux_i_span_mv(is_mv), .aux_i_top_mv(it_mv), .aux_q_span_mv(qs_mv), .aux_q_top_mv(qt_mv),
      .reference_trim_code(trim), .q_cal_ref_preload(qpre), .i_cal_ref_preload(ipre),
      .cal_tick(cal_tick), .cal_busy(cal_busy), .q_cal_done(q_done), .i_cal_done(i_done));

   ////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Closing report, the single end of the run
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Read with the expected byte noted first
   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.xfer(1'b0, a, 8'h00);
   endtask

   // Fields land one cycle after a write, millivolt outputs one more
   task automatic settle;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   // Cycles until the next calibration tick, capped at 600
   task automatic gap(output int k);
      k = 0;
      do begin
         @(posedge ref_clk);
         #1;
         k++;
      end while (!cal_tick && k < 600);
   endtask

   // Bounded wait for the sequencer to go idle
   task automatic wait_idle;
      n = 0;
      while (cal_busy && n < 200) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
   endtask

   ////////////////////////////////////////
   // Read data is due exactly one cycle after the read edge
   always @(posedge ref_clk) begin
      if (rd_d && exp_q.size() > 0) begin
         e_v = exp_q.pop_front();
         `CHK("reg_rdata", e_v, reg_rdata)
      end
      rd_d <= reg_rd_en;
   end

   // Hang guard: about ten times the expected run
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end

   ////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      // Reset values, read-only, strobe-only and unmapped places
      foreach (addrs[i]) rdx(addrs[i], 8'h00);
      `CHK("q span", 12'h7D0, qs_mv)
      `CHK("q top", 12'h3E8, qt_mv)
      `CHK("q preload", 6'h20, qpre)
      `CHK("i preload", 6'h20, ipre)
      // Random level words split over two bytes each
      repeat (4) begin
         seed = xs(seed);
         host.xfer(1'b1, 8'h0B, seed[7:0]);
         host.xfer(1'b1, 8'h0C, {6'h00, seed[9:8]});
         host.xfer(1'b1, 8'h09, seed[15:8]);
         host.xfer(1'b1, 8'h0A, {6'h00, seed[17:16]});
         settle();
         `CHK("q level", seed[9:0], aux_q_cfg.level)
         `CHK("i level", {seed[17:16], seed[15:8]}, aux_i_cfg.level)
         rdx(8'h0B, seed[7:0]);
      end
      // Every span code and top codes 0 to 4, enable toggling
      for (int k = 0; k < 5; k++) begin
         host.xfer(1'b1, 8'h0C, {k[0], k[1:0], k[2:0], 2'b00});
         host.xfer(1'b1, 8'h0A, {1'b0, ~k[1:0], k[2:0], 2'b00});
         settle();
         `CHK("q span", span_t[k[1:0]], qs_mv)
         `CHK("q top", top_t[k], qt_mv)
         `CHK("q enable", k[0], aux_q_cfg.enable)
         `CHK("i top", top_t[k], it_mv)
         `CHK("i span", span_t[~k[1:0]], is_mv)
      end
      // Trim extremes; upper bits read back as zero
      host.xfer(1'b1, 8'h0D, 8'hDF);
      settle();
      `CHK("trim", 6'h1F, trim)
      rdx(8'h0D, 8'h1F);
      host.xfer(1'b1, 8'h0D, 8'h60);
      settle();
      `CHK("trim", 6'h20, trim)
      // Preload source per channel
      seed = xs(seed);
      @(posedge ref_clk) user_cal_ref <= seed[5:0];
      host.xfer(1'b1, 8'h0E, 8'h80);
      settle();
      `CHK("q preload", seed[5:0], qpre)
      `CHK("i preload", 6'h20, ipre)
      host.xfer(1'b1, 8'h0E, 8'h40);
      settle();
      `CHK("i preload", seed[5:0], ipre)
      `CHK("q preload", 6'h20, qpre)
      // Stopped clock stays quiet
      host.xfer(1'b1, 8'h0E, 8'h07);
      gap(n);
      `CHK("no tick", 600, n)
      // Each divide code set while stopped, then measured
      for (int c = 0; c < 8; c++) begin
         host.xfer(1'b1, 8'h0E, 8'(c));
         host.xfer(1'b1, 8'h0E, 8'(8 + c));
         gap(n);
         gap(n);
         `CHK("tick gap", 256 >> c, n)
      end
      // Q self-calibration, then a memory control write with the start bit clear
      host.xfer(1'b1, 8'h0E, 8'h27);
      host.xfer(1'b1, 8'h0E, 8'h2F);
      host.xfer(1'b1, 8'h12, 8'h10);
      #1;
      `CHK("busy", 1'b1, cal_busy)
      `CHK("q done", 1'b0, q_done)
      wait_idle();
      `CHK("q done", 1'b1, q_done)
      rdx(8'h0F, 8'h84);
      host.xfer(1'b1, 8'h12, 8'hEF);
      #1;
      `CHK("busy", 1'b0, cal_busy)
      // I self-calibration leaves Q status alone
      host.xfer(1'b1, 8'h0E, 8'h17);
      host.xfer(1'b1, 8'h0E, 8'h1F);
      host.xfer(1'b1, 8'h12, 8'h10);
      #1;
      `CHK("i done", 1'b0, i_done)
      `CHK("q done", 1'b1, q_done)
      wait_idle();
      rdx(8'h0F, 8'hC5);
      // Second Q run clears only the Q done flag
      host.xfer(1'b1, 8'h0E, 8'h27);
      host.xfer(1'b1, 8'h0E, 8'h2F);
      host.xfer(1'b1, 8'h12, 8'h10);
      #1;
      `CHK("q done", 1'b0, q_done)
      `CHK("i done", 1'b1, i_done)
      wait_idle();
      rdx(8'h0F, 8'hC5);
      repeat (3) @(posedge ref_clk);
      give_verdict();
   end
endmodule
